/* dv/fbs_cfg_sup_test.sv */
// Self-checking bench for the config supervisor
`timescale 1ns/1ns
module fbs_cfg_sup_test
  import fbs_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  fbs_wr_t     wr = '0;
  fbs_orst_t   orst_in = '0;
  fbs_remote_t remote;
  logic        orst_wr = 1'b0, out_reset = 1'b0, nv_station_valid = 1'b0;
  logic        link_error_pin = 1'b0, diag_anomaly_pin = 1'b0, err_reset_req = 1'b0;
  logic [31:0] app_send_data = '0, send_data, v1, v2, c2;
  logic [6:0]  nv_station = '0, flash_data, station_number_param;
  logic [16:0] ext_stop_input_sel, exp_stop, d;
  logic [15:0] error_check_interval, error_code;
  logic [1:0]  card_operating_mode, master_class_sel, em, ec;
  logic        wr_ack, wr_reject, flash_wr, flash_erase, stop_input_used, station_lock, ok;
  logic        net_attached, data_exchange_en, error_reset_override, card_error;
  logic        fb_error, diag_error;
  logic [16:0] tv [5] = '{17'h7cf, 17'h7d0, 17'hf6f, 17'hf70, 17'h1ffff};
  int          errors = 0, check_count = 0, n;

  fbs_cfg_sup #(.CLKS_MS(10)) i_fbs_cfg_sup (
    .core_clk, .rst, .wr, .wr_ack, .wr_reject, .orst_wr, .orst_in, .out_reset,
    .app_send_data, .send_data, .remote, .nv_station_valid, .nv_station, .flash_wr,
    .flash_erase, .flash_data, .link_error_pin, .diag_anomaly_pin, .err_reset_req,
    .ext_stop_input_sel, .stop_input_used, .card_operating_mode, .master_class_sel,
    .station_number_param, .station_lock, .net_attached, .data_exchange_en,
    .error_reset_override, .error_check_interval, .card_error, .fb_error, .diag_error,
    .error_code);

  fbs_master_model i_fbs_master_model (.core_clk, .remote);

  // Clock
  always #5 core_clk = ~core_clk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_v

  task automatic chk_b(input logic got, input logic exp, input string m);
    chk_v({31'h0, got}, {31'h0, exp}, m);
  endtask : chk_b

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick

  // Software write, answer checked just after the edge that takes it
  task automatic wr_do(input fbs_sel_t s, input logic [16:0] dd, input logic ok_e);
    @(posedge core_clk);
    wr <= '{1'b1, s, dd};
    @(posedge core_clk);
    wr.valid <= 1'b0;
    #1;
    chk_b(wr_ack, ok_e, "ack");
    chk_b(wr_reject, !ok_e, "reject");
  endtask : wr_do

  // Bounded wait for card_error (w=0) or diag_error (w=1)
  task automatic wait_hi(input int w, input int lim, output int cyc);
    cyc = 0;
    while ((w ? diag_error : card_error) !== 1'b1)
    begin
      tick(1);
      cyc++;
      if (cyc > lim)
      begin
        errors++;
        $display("wrong value at %0t: wait ran out", $time);
        give_verdict();
      end
    end
  endtask : wait_hi

  task automatic pulse_reset_req();
    @(posedge core_clk);
    err_reset_req <= 1'b1;
    @(posedge core_clk);
    err_reset_req <= 1'b0;
    tick(1);
  endtask : pulse_reset_req

  // Optionally load a pattern, then apply an output reset
  task automatic do_orst(input logic ld, input logic [31:0] v, input logic [31:0] c);
    if (ld)
    begin
      @(posedge core_clk);
      orst_in <= '{v, c};
      orst_wr <= 1'b1;
    end
    @(posedge core_clk);
    orst_wr <= 1'b0;
    out_reset <= 1'b1;
    @(posedge core_clk);
    out_reset <= 1'b0;
    #1;
  endtask : do_orst

  task automatic chk_defaults();
    chk_v(ext_stop_input_sel, 17'h1ffff, "stop rst");
    chk_v(card_operating_mode, 2'h0, "mode rst");
    chk_v(master_class_sel, 2'h1, "class rst");
    chk_v(station_number_param, 7'h7e, "station rst");
    chk_b(error_reset_override, 1'b0, "ovr rst");
    chk_v(error_check_interval, 16'h0028, "ival rst");
    chk_v(send_data, 32'h0, "send rst");
  endtask : chk_defaults

  function automatic logic stop_ok(input logic [16:0] x);
    return x == 17'h1ffff || (x >= 17'h7d0 && x <= 17'hf6f);
  endfunction : stop_ok

  // Main sequence
  initial
  begin
    void'($urandom(32'hddd2));
    tick(2);
    chk_defaults();
    @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    exp_stop = 17'h1ffff;
    for (n = 0; n < 11; n++)
    begin
      d = (n < 5) ? tv[n] : 17'($urandom_range(4200, 1900));
      ok = stop_ok(d);
      if (ok)
        exp_stop = d;
      wr_do(FBS_SEL_STOP, d, ok);
      chk_v(ext_stop_input_sel, exp_stop, "stop");
      chk_b(stop_input_used, exp_stop != 17'h1ffff, "used");
    end
    em = 2'h0;
    ec = 2'h1;
    for (n = 3; n >= 0; n--)
    begin
      wr_do(FBS_SEL_MODE, 17'(n), n == 0 || n == 2);
      em = (n == 0 || n == 2) ? 2'(n) : em;
      chk_v(card_operating_mode, em, "mode");
      wr_do(FBS_SEL_CLASS, 17'(n), n == 1 || n == 2);
      ec = (n == 1 || n == 2) ? 2'(n) : ec;
      chk_v(master_class_sel, ec, "class");
    end
    $display("test parameters done");
    wr_do(FBS_SEL_STATION, 17'h7e, 1'b0);
    chk_b(data_exchange_en, 1'b0, "xchg off");
    wr_do(FBS_SEL_STATION, 17'h5, 1'b1);
    chk_b(flash_wr, 1'b1, "flash wr");
    chk_v(flash_data, 7'h5, "flash data");
    v1 = $urandom();
    app_send_data <= v1;
    tick(2);
    chk_b(net_attached, 1'b1, "attached");
    chk_v(send_data, v1, "exchange");
    wr_do(FBS_SEL_STATION, 17'h1ffff, 1'b1);
    chk_b(flash_erase, 1'b1, "erase");
    chk_v(station_number_param, 7'h7e, "cleared");
    app_send_data <= ~v1;
    tick(3);
    chk_v(send_data, v1, "detached");
    $display("test station done");
    i_fbs_master_model.assign_addr(7'ha, 1'b1);
    #1;
    chk_v(station_number_param, 7'h7e, "class1 remote");
    wr_do(FBS_SEL_CLASS, 17'h2, 1'b1);
    wr_do(FBS_SEL_STATION, 17'h9, 1'b0);
    i_fbs_master_model.assign_addr(7'ha, 1'b1);
    #1;
    chk_v(station_number_param, 7'ha, "remote");
    chk_b(station_lock, 1'b1, "lock");
    chk_v(flash_data, 7'ha, "remote flash");
    i_fbs_master_model.assign_addr(7'h14, 1'b0);
    #1;
    chk_v(station_number_param, 7'ha, "locked remote");
    wr_do(FBS_SEL_STATION, 17'h1ffff, 1'b1);
    chk_b(station_lock, 1'b0, "unlock");
    wr_do(FBS_SEL_CLASS, 17'h1, 1'b1);
    $display("test remote done");
    do_orst(1'b0, '0, '0);
    chk_v(send_data, 32'h0, "orst default");
    do_orst(1'b1, v1, '1);
    chk_v(send_data, v1, "orst full");
    v2 = $urandom();
    c2 = $urandom();
    do_orst(1'b1, v2, c2);
    chk_v(send_data, (v2 & c2) | (v1 & ~c2), "orst care");
    $display("test output reset done");
    wr_do(FBS_SEL_STATION, 17'h3, 1'b1);
    wr_do(FBS_SEL_INTERVAL, 17'h10000, 1'b0);
    wr_do(FBS_SEL_INTERVAL, 17'hffff, 1'b1);
    chk_v(error_check_interval, 16'hffff, "ival max");
    chk_b(data_exchange_en, 1'b1, "xchg on");
    wr_do(FBS_SEL_INTERVAL, 17'h0, 1'b1);
    link_error_pin <= 1'b1;
    wait_hi(0, 10, n);
    chk_b(n <= 6, 1'b1, "immediate");
    tick(2);
    chk_v(error_code, 16'h8500, "link code");
    pulse_reset_req();
    chk_b(fb_error, 1'b1, "kept");
    wr_do(FBS_SEL_OVERRIDE, 17'h2, 1'b0);
    wr_do(FBS_SEL_OVERRIDE, 17'h1, 1'b1);
    chk_b(error_reset_override, 1'b1, "ovr set");
    pulse_reset_req();
    chk_b(fb_error, 1'b0, "override");
    chk_b(data_exchange_en, 1'b0, "stopped");
    link_error_pin <= 1'b0;
    wr_do(FBS_SEL_INTERVAL, 17'h1, 1'b1);
    tick(8);
    link_error_pin <= 1'b1;
    tick(7);
    link_error_pin <= 1'b0;
    tick(20);
    chk_b(card_error | fb_error, 1'b0, "short");
    link_error_pin <= 1'b1;
    wait_hi(0, 40, n);
    chk_b(n >= 10 && n <= 16, 1'b1, "persist");
    link_error_pin <= 1'b0;
    tick(8);
    pulse_reset_req();
    // Operators keep the interval in the usual noisy-site band
    wr_do(FBS_SEL_INTERVAL, 17'h46, 1'b1);
    chk_v(error_check_interval, 16'h46, "ival band");
    $display("test errors done");
    wr_do(FBS_SEL_MODE, 17'h2, 1'b1);
    diag_anomaly_pin <= 1'b1;
    wait_hi(1, 12, n);
    tick(1);
    chk_v(error_code, 16'h8504, "diag code");
    diag_anomaly_pin <= 1'b0;
    tick(6);
    chk_b(diag_error, 1'b1, "diag held");
    wr_do(FBS_SEL_MODE, 17'h0, 1'b1);
    tick(1);
    chk_v(error_code, 16'h0, "diag cleared");
    $display("test diagnosis done");
    @(posedge core_clk);
    nv_station_valid <= 1'b1;
    nv_station <= 7'h21;
    rst <= 1'b1;
    tick(2);
    chk_defaults();
    @(posedge core_clk);
    rst <= 1'b0;
    tick(2);
    chk_v(station_number_param, 7'h21, "stored station");
    $display("test second reset done");
    give_verdict();
  end
endmodule : fbs_cfg_sup_test

/* dv/fbs_master_model.sv */
// Fieldbus master model that assigns the slave station number remotely
`timescale 1ns/1ns
module fbs_master_model
  import fbs_pkg::*;
(
  input  wire logic  core_clk,
  output fbs_remote_t remote
);
  initial remote = '0;

  // One-cycle assignment; released lines show the inverse of the last value
  task automatic assign_addr(input logic [6:0] a, input logic lk);
    @(posedge core_clk);
    remote <= '{1'b1, a, lk};
    @(posedge core_clk);
    remote <= '{1'b0, ~a, ~lk};
  endtask : assign_addr
endmodule : fbs_master_model

/* hw/fbs_cfg_sup.sv */
// Configuration and error supervision for the fieldbus slave card
`timescale 1ns/1ns
module fbs_cfg_sup
  import fbs_pkg::*;
#(
  parameter int CLKS_MS = CLKS_PER_MS
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire fbs_wr_t     wr,
  output logic             wr_ack,
  output logic             wr_reject,
  input  wire logic        orst_wr,
  input  wire fbs_orst_t   orst_in,
  input  wire logic        out_reset,
  input  wire logic [31:0] app_send_data,
  output logic [31:0]      send_data,
  input  wire fbs_remote_t remote,
  input  wire logic        nv_station_valid,
  input  wire logic [6:0]  nv_station,
  output logic             flash_wr,
  output logic             flash_erase,
  output logic [6:0]       flash_data,
  input  wire logic        link_error_pin,
  input  wire logic        diag_anomaly_pin,
  input  wire logic        err_reset_req,
  output logic [16:0]      ext_stop_input_sel,
  output logic             stop_input_used,
  output logic [1:0]       card_operating_mode,
  output logic [1:0]       master_class_sel,
  output logic [6:0]       station_number_param,
  output logic             station_lock,
  output logic             net_attached,
  output logic             data_exchange_en,
  output logic             error_reset_override,
  output logic [15:0]      error_check_interval,
  output logic             card_error,
  output logic             fb_error,
  output logic             diag_error,
  output logic [15:0]      error_code
);

  // True when all bits of d at and above position w are zero
  function automatic logic hi_zero(input logic [16:0] d, input int w);
    logic z;
    z = 1'b1;
    for (int i = 0; i < 17; i++)
      if (i >= w && d[i])
        z = 1'b0;
    return z;
  endfunction : hi_zero

  logic        boot;
  logic        wr_ok;
  logic        wr_take;
  logic        station_clear;
  logic        station_local;
  logic        remote_take;
  logic        filt_err;
  logic        filt_err_d;
  logic [1:0]  sync0;
  logic [1:0]  sync1;
  logic [1:0]  sync2;
  logic [1:0]  pin_raw;
  logic [1:0]  pin_ok;
  fbs_orst_t   orst;

  assign pin_raw = {diag_anomaly_pin, link_error_pin};

  // Three-stage pin synchronisers, value accepted when stages two and three agree
  for (genvar g = 0; g < 2; g++)
  begin : g_sync
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        sync0[g]  <= 1'b0;
        sync1[g]  <= 1'b0;
        sync2[g]  <= 1'b0;
        pin_ok[g] <= 1'b0;
      end
      else
      begin
        sync0[g] <= pin_raw[g];
        sync1[g] <= sync0[g];
        sync2[g] <= sync1[g];
        if (sync1[g] == sync2[g])
          pin_ok[g] <= sync2[g];
      end
    end
  end

  // Range check of a software write against its parameter
  always_comb
  begin
    wr_ok = 1'b0;
    case (wr.sel)
      FBS_SEL_STOP:
        wr_ok = (wr.data == PARAM_NEG_ONE) ||
                (wr.data >= STOP_MIN && wr.data <= STOP_MAX);
      FBS_SEL_MODE:
        wr_ok = hi_zero(wr.data, 2) &&
                (wr.data[1:0] == MODE_NORMAL || wr.data[1:0] == MODE_DIAG);
      FBS_SEL_CLASS:
        wr_ok = hi_zero(wr.data, 2) &&
                (wr.data[1:0] == CLASS_1 || wr.data[1:0] == CLASS_2);
      FBS_SEL_STATION:
        wr_ok = (wr.data == PARAM_NEG_ONE) ||
                (!station_lock && master_class_sel == CLASS_1 &&
                 hi_zero(wr.data, 7) && wr.data[6:0] <= STATION_MAX);
      FBS_SEL_OVERRIDE:
        wr_ok = hi_zero(wr.data, 1);
      FBS_SEL_INTERVAL:
        wr_ok = hi_zero(wr.data, 16);
      default:
        wr_ok = 1'b0;
    endcase
  end

  assign wr_take       = wr.valid && wr_ok;
  assign station_clear = wr_take && wr.sel == FBS_SEL_STATION && wr.data == PARAM_NEG_ONE;
  assign station_local = wr_take && wr.sel == FBS_SEL_STATION && !station_clear;
  assign remote_take   = remote.valid && master_class_sel == CLASS_2 && !station_lock &&
                         remote.addr <= STATION_MAX && !boot && !station_clear;

  // Write acknowledge pulses
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ack    <= 1'b0;
      wr_reject <= 1'b0;
    end
    else
    begin
      wr_ack    <= wr_take;
      wr_reject <= wr.valid && !wr_ok;
    end
  end

  // Plain parameter registers; override needs no restart and powers up clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_stop_input_sel   <= STOP_RESET;
      card_operating_mode  <= MODE_RESET;
      master_class_sel     <= CLASS_RESET;
      error_reset_override <= OVERRIDE_RESET;
      error_check_interval <= INTERVAL_RESET;
    end
    else if (wr_take)
    begin
      case (wr.sel)
        FBS_SEL_STOP:     ext_stop_input_sel   <= wr.data;
        FBS_SEL_MODE:     card_operating_mode  <= wr.data[1:0];
        FBS_SEL_CLASS:    master_class_sel     <= wr.data[1:0];
        FBS_SEL_OVERRIDE: error_reset_override <= wr.data[0];
        FBS_SEL_INTERVAL: error_check_interval <= wr.data[15:0];
        default:          ;
      endcase
    end
  end

  assign stop_input_used = (ext_stop_input_sel != PARAM_NEG_ONE);

  // Station number, lock and restore of the stored copy after reset
  // A software write on the first edge beats the restore, so flash and address agree
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      boot                 <= 1'b1;
      station_number_param <= STATION_RESET;
      station_lock         <= 1'b0;
    end
    else
    begin
      boot <= 1'b0;
      if (station_clear)
      begin
        station_number_param <= STATION_DETACHED;
        station_lock         <= 1'b0;
      end
      else if (station_local)
        station_number_param <= wr.data[6:0];
      else if (remote_take)
      begin
        station_number_param <= remote.addr;
        station_lock         <= remote.lock;
      end
      else if (boot && nv_station_valid && nv_station <= STATION_MAX)
        station_number_param <= nv_station;
    end
  end

  // Non-volatile copy update and erase requests
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      flash_wr    <= 1'b0;
      flash_erase <= 1'b0;
      flash_data  <= STATION_RESET;
    end
    else
    begin
      flash_wr    <= station_local || remote_take;
      flash_erase <= station_clear;
      if (station_local)
        flash_data <= wr.data[6:0];
      else if (remote_take)
        flash_data <= remote.addr;
    end
  end

  assign net_attached = (station_number_param != STATION_DETACHED);

  // Output-reset pattern storage
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      orst.value <= ORST_VAL_RESET;
      orst.care  <= ORST_CARE_RESET;
    end
    else if (orst_wr)
      orst <= orst_in;
  end

  // Send data: output reset applies pattern, don't-care bits hold
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      send_data <= ORST_VAL_RESET;
    else if (out_reset)
      send_data <= (orst.value & orst.care) | (send_data & ~orst.care);
    else if (data_exchange_en && net_attached)
      send_data <= app_send_data;
  end

  // Card error persistence filter
  fbs_err_filter #(
    .CLKS_MS (CLKS_MS)
  ) u_filter (
    .core_clk (core_clk),
    .rst      (rst),
    .err_in   (pin_ok[0]),
    .interval (error_check_interval),
    .err_out  (filt_err)
  );

  assign card_error = filt_err;

  // Link error latch: a new error beats a reset request in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      filt_err_d <= 1'b0;
      fb_error   <= 1'b0;
    end
    else
    begin
      filt_err_d <= filt_err;
      if (filt_err && !filt_err_d)
        fb_error <= 1'b1;
      else if (err_reset_req && (error_reset_override || !filt_err))
        fb_error <= 1'b0;
    end
  end

  // Self-diagnosis error, held until the mode returns to normal on an edge with no anomaly flagged
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      diag_error <= 1'b0;
    else if (card_operating_mode == MODE_DIAG && pin_ok[1])
      diag_error <= 1'b1;
    else if (wr_take && wr.sel == FBS_SEL_MODE && wr.data[1:0] == MODE_NORMAL)
      diag_error <= 1'b0;
  end

  // Exchange gate and shown error code
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      data_exchange_en <= 1'b0;
      error_code       <= ERR_CODE_NONE;
    end
    else
    begin
      data_exchange_en <= net_attached && !filt_err && !fb_error && !diag_error &&
                          card_operating_mode == MODE_NORMAL;
      error_code <= diag_error ? ERR_CODE_DIAG : (fb_error ? ERR_CODE_LINK : ERR_CODE_NONE);
    end
  end

  a_stop_range : assert property (@(posedge core_clk) disable iff (rst)
    stop_input_used |-> (ext_stop_input_sel >= STOP_MIN && ext_stop_input_sel <= STOP_MAX))
    else $error("Stop select out of range");

  a_clear_gives_126 : assert property (@(posedge core_clk) disable iff (rst)
    (station_clear && !boot) |=> (station_number_param == STATION_DETACHED && flash_erase
     && !station_lock))
    else $error("Station clear did not detach and erase");

  a_station_write_flash : assert property (@(posedge core_clk) disable iff (rst)
    (station_local && !boot) |=> (flash_wr && station_number_param == flash_data))
    else $error("Station write did not update flash copy");

  a_detached_no_xfer : assert property (@(posedge core_clk) disable iff (rst)
    $past(!net_attached) |-> !data_exchange_en)
    else $error("Exchange while detached");

  a_detached_send_hold : assert property (@(posedge core_clk) disable iff (rst)
    (!net_attached && !out_reset) |=> $stable(send_data))
    else $error("Send data changed while detached");

  a_lock_refuses : assert property (@(posedge core_clk) disable iff (rst)
    (station_lock && !station_clear && !boot) |=> $stable(station_number_param))
    else $error("Station changed while locked");

  a_diag_error_code : assert property (@(posedge core_clk) disable iff (rst)
    (card_operating_mode == MODE_DIAG && pin_ok[1]) |=> diag_error ##1
    (error_code == ERR_CODE_DIAG))
    else $error("Diagnosis anomaly not reported");

  a_no_override_hold : assert property (@(posedge core_clk) disable iff (rst)
    (!error_reset_override && fb_error && filt_err) |=> fb_error)
    else $error("Link error cleared during anomaly");

  a_orst_pattern : assert property (@(posedge core_clk) disable iff (rst)
    out_reset |=> (send_data == (($past(orst.value) & $past(orst.care)) |
                   ($past(send_data) & ~$past(orst.care)))))
    else $error("Output reset pattern not applied");

endmodule : fbs_cfg_sup

/* hw/fbs_err_filter.sv */
// Persistence filter for the card error, measured in milliseconds
`timescale 1ns/1ns
module fbs_err_filter
  import fbs_pkg::*;
#(
  parameter int CLKS_MS = CLKS_PER_MS
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        err_in,
  input  wire logic [15:0] interval,
  output logic             err_out
);

  logic [31:0] pre;
  logic [15:0] ms_cnt;
  logic        ms_tick;

  assign ms_tick = (pre == 32'(CLKS_MS - 1));

  // Count whole milliseconds of uninterrupted error, restart on any gap
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pre    <= 32'h0;
      ms_cnt <= 16'h0;
    end
    else if (!err_in)
    begin
      pre    <= 32'h0;
      ms_cnt <= 16'h0;
    end
    else
    begin
      pre <= ms_tick ? 32'h0 : pre + 32'h1;
      if (ms_tick && ms_cnt != 16'hffff)
        ms_cnt <= ms_cnt + 16'h1;
    end
  end

  // Zero reports at once, otherwise only after the whole interval
  assign err_out = err_in && ((interval == 16'h0) || (ms_cnt >= interval));

  a_zero_is_immediate : assert property (@(posedge core_clk) disable iff (rst)
    (interval == 16'h0 && err_in) |-> err_out)
    else $error("Zero interval did not report error at once");

  a_short_episode_hidden : assert property (@(posedge core_clk) disable iff (rst)
    (interval != 16'h0 && $rose(err_in)) |-> !err_out)
    else $error("Error reported before interval elapsed");

endmodule : fbs_err_filter

/* hw/fbs_pkg.sv */
// Shared constants and carrier types for the fieldbus slave config supervisor
package fbs_pkg;

  // Widths
  localparam int DATA_W    = 17;
  localparam int SEND_W    = 32;
  localparam int STATION_W = 7;

  // Parameter values and ranges
  localparam logic [16:0] PARAM_NEG_ONE    = 17'h1ffff;
  localparam logic [16:0] STOP_MIN         = 17'h007d0;
  localparam logic [16:0] STOP_MAX         = 17'h00f6f;
  localparam logic [1:0]  MODE_NORMAL      = 2'h0;
  localparam logic [1:0]  MODE_DIAG        = 2'h2;
  localparam logic [1:0]  CLASS_1          = 2'h1;
  localparam logic [1:0]  CLASS_2          = 2'h2;
  localparam logic [6:0]  STATION_MAX      = 7'h7d;
  localparam logic [6:0]  STATION_DETACHED = 7'h7e;

  // Reset values
  localparam logic [16:0] STOP_RESET     = 17'h1ffff;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam logic [1:0]  CLASS_RESET    = 2'h1;
  localparam logic [6:0]  STATION_RESET  = 7'h7e;
  localparam logic        OVERRIDE_RESET = 1'h0;
  localparam logic [15:0] INTERVAL_RESET = 16'h0028;
  localparam logic [31:0] ORST_VAL_RESET = 32'h00000000;
  localparam logic [31:0] ORST_CARE_RESET = 32'hffffffff;

  // Error codes shown to the controller
  localparam logic [15:0] ERR_CODE_NONE = 16'h0000;
  localparam logic [15:0] ERR_CODE_LINK = 16'h8500;
  localparam logic [15:0] ERR_CODE_DIAG = 16'h8504;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int CLKS_PER_MS   = MS_NS / CLK_PERIOD_NS;

  // Parameter selector of a software write
  typedef enum logic [2:0] {
    FBS_SEL_STOP,
    FBS_SEL_MODE,
    FBS_SEL_CLASS,
    FBS_SEL_STATION,
    FBS_SEL_OVERRIDE,
    FBS_SEL_INTERVAL
  } fbs_sel_t;

  // Software parameter write
  typedef struct packed {
    logic        valid;
    fbs_sel_t    sel;
    logic [16:0] data;
  } fbs_wr_t;

  // Output-reset pattern: value per bit, care=0 means keep current bit
  typedef struct packed {
    logic [31:0] value;
    logic [31:0] care;
  } fbs_orst_t;

  // Remote station assignment from a class 2 master
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic       lock;
  } fbs_remote_t;

endpackage : fbs_pkg
